/* File: hw/cit_cycle_counter.sv */
// Down-counter that measures one instruction's execution time.
// Assumes load is a one-cycle pulse given while the count is idle.
`timescale 1ns/1ns
module cit_cycle_counter
    import cit_timing_pkg::*;
#(
    parameter int CYC_W = CIT_CYC_W
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             load,
    input  wire logic [CYC_W-1:0] load_value,
    output logic      [CYC_W-1:0] remaining,
    output logic                  last
);

    typedef struct packed {
        logic [CYC_W-1:0] count;
    } cit_cnt_type;

    cit_cnt_type st;
    cit_cnt_type next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.count = load_value;
        end else if (st.count != CYC_W'(0)) begin
            next_st.count = st.count - CYC_W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign remaining = st.count;
    assign last      = (st.count == CYC_W'(1));

endmodule

/* File: hw/cit_instruction_timing.sv */
// Instruction length and cycle-timing decoder with an execution sequencer.
// Assumes the fetch logic offers opcodes synchronous to clk, with the
// branch outcome valid alongside a conditional branch opcode.
//
// What this block does
// - Durations counted only in system clock cycles
// - Most instructions: cycles equal byte length
// - Untaken conditional branch one cycle shorter
// - ADD/ADDC/SUBB register: one byte, one cycle
// - Arithmetic with direct source: two, two
// - Pointer-indirect ALU source: one byte, two cycles
// - Immediate arithmetic: two bytes, two cycles
// - Logic immediate into direct: three, three
// - Logic accumulator into direct: two, two
// - Logic register into accumulator: one, one
// - Accumulator-only single-byte ops: one cycle
// - Direct-to-direct or immediate-to-direct moves: three, three
// - Load sixteen-bit pointer: three bytes, three cycles
// - Code-memory reads: one byte, three cycles
// - External data moves: one byte, three cycles
// - Stack push/pop direct: two, two
// - Exchange: register one, others two cycles
// - Indirect RAM writes: two cycles
// - Register load direct/immediate: two, two
// - No instruction exceeds eight cycles
`timescale 1ns/1ns
module cit_instruction_timing
    import cit_timing_pkg::*;
#(
    parameter int CYC_W      = CIT_CYC_W,
    parameter int MAX_CYCLES = CIT_MAX_CYCLES_INT
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   op_valid,
    input  wire logic [7:0]             opcode,
    input  wire logic                   branch_taken,
    output logic                        op_ready,
    output logic      [CIT_BYTES_W-1:0] instr_bytes,
    output logic      [CYC_W-1:0]       instr_cycles,
    output logic                        cond_branch,
    output logic                        busy,
    output logic                        next_fetch
);

    if (CYC_W < 4 || MAX_CYCLES > 8 || MAX_CYCLES < 1) begin : g_check
        $error("cit_instruction_timing: CYC_W or MAX_CYCLES out of range");
    end

    typedef struct packed {
        cit_state_type          state;
        logic                   ready;
        logic                   busy;
        logic [CIT_BYTES_W-1:0] bytes;
        logic [CYC_W-1:0]       cycles;
        logic                   cond;
        logic                   next_fetch;
    } cit_seq_type;

    cit_seq_type st;
    cit_seq_type next_st;

    logic [1:0]       dec_bytes;
    logic [3:0]       dec_cycles;
    logic             dec_cond;
    logic [3:0]       total_cycles;
    logic             cnt_load;
    logic             cnt_last;
    logic [CYC_W-1:0] cnt_remaining;

    // Opcode table: length, not-taken cycle count, conditional flag
    always_comb begin
        dec_bytes  = 2'h1;
        dec_cycles = 4'h1;
        dec_cond   = 1'b0;
        if (opcode[3]) begin
            case (opcode[7:4])
                4'h7, 4'h8, 4'hA: begin
                    dec_bytes  = 2'h2;
                    dec_cycles = 4'h2;
                end
                4'hB: begin
                    dec_bytes  = 2'h3;
                    dec_cycles = 4'h3;
                    dec_cond   = 1'b1;
                end
                4'hD: begin
                    dec_bytes  = 2'h2;
                    dec_cycles = 4'h2;
                    dec_cond   = 1'b1;
                end
                default: begin
                    dec_bytes  = 2'h1;
                    dec_cycles = 4'h1;
                end
            endcase
        end else begin
            case (opcode[3:0])
                4'h6, 4'h7: begin
                    dec_cycles = 4'h2;
                    case (opcode[7:4])
                        4'h7, 4'h8, 4'hA: dec_bytes = 2'h2;
                        4'hB: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h4;
                            dec_cond   = 1'b1;
                        end
                        default: dec_bytes = 2'h1;
                    endcase
                end
                4'h5: begin
                    dec_bytes  = 2'h2;
                    dec_cycles = 4'h2;
                    case (opcode[7:4])
                        4'h7, 4'h8: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h3;
                        end
                        4'hA: begin
                            dec_bytes  = 2'h1;
                            dec_cycles = 4'h1;
                        end
                        4'hB: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h4;
                            dec_cond   = 1'b1;
                        end
                        4'hD: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h3;
                            dec_cond   = 1'b1;
                        end
                        default: dec_bytes = 2'h2;
                    endcase
                end
                4'h4: begin
                    case (opcode[7:4])
                        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin
                            dec_bytes  = 2'h2;
                            dec_cycles = 4'h2;
                        end
                        4'h8: dec_cycles = 4'h8;
                        4'hA: dec_cycles = 4'h4;
                        4'hB: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h3;
                            dec_cond   = 1'b1;
                        end
                        default: dec_cycles = 4'h1;
                    endcase
                end
                4'h3: begin
                    case (opcode[7:4])
                        4'h4, 4'h5, 4'h6: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h3;
                        end
                        4'h7, 4'h8, 4'h9, 4'hE, 4'hF: dec_cycles = 4'h3;
                        default: dec_cycles = 4'h1;
                    endcase
                end
                4'h2: begin
                    case (opcode[7:4])
                        4'h0, 4'h1: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h4;
                        end
                        4'h2, 4'h3: dec_cycles = 4'h5;
                        4'hE, 4'hF: dec_cycles = 4'h3;
                        default: begin
                            dec_bytes  = 2'h2;
                            dec_cycles = 4'h2;
                        end
                    endcase
                end
                4'h1: begin
                    dec_bytes  = 2'h2;
                    dec_cycles = 4'h3;
                end
                default: begin
                    case (opcode[7:4])
                        4'h0: dec_cycles = 4'h1;
                        4'h1, 4'h2, 4'h3: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h3;
                            dec_cond   = 1'b1;
                        end
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            dec_bytes  = 2'h2;
                            dec_cycles = 4'h2;
                            dec_cond   = 1'b1;
                        end
                        4'h8: begin
                            dec_bytes  = 2'h2;
                            dec_cycles = 4'h3;
                        end
                        4'h9: begin
                            dec_bytes  = 2'h3;
                            dec_cycles = 4'h3;
                        end
                        4'hE, 4'hF: dec_cycles = 4'h3;
                        default: begin
                            dec_bytes  = 2'h2;
                            dec_cycles = 4'h2;
                        end
                    endcase
                end
            endcase
        end
    end

    // Taken branch costs one cycle more than the untaken path
    assign total_cycles = (dec_cond && branch_taken) ?
                          dec_cycles + CIT_TAKEN_EXTRA : dec_cycles;

    always_comb begin
        next_st            = st;
        next_st.next_fetch = 1'b0;
        cnt_load           = 1'b0;
        case (st.state)
            CIT_IDLE: begin
                if (op_valid) begin
                    next_st.bytes  = dec_bytes;
                    next_st.cycles = CYC_W'(total_cycles);
                    next_st.cond   = dec_cond;
                    next_st.busy   = 1'b1;
                    next_st.ready  = 1'b0;
                    next_st.state  = CIT_EXEC;
                    cnt_load       = 1'b1;
                end
            end
            CIT_EXEC: begin
                // Fetch released only once the full count has run
                if (cnt_last) begin
                    next_st.state      = CIT_IDLE;
                    next_st.busy       = 1'b0;
                    next_st.ready      = 1'b1;
                    next_st.next_fetch = 1'b1;
                end
            end
            default: next_st.state = CIT_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{state: CIT_IDLE, ready: 1'b1, busy: 1'b0, bytes: CIT_BYTES_RST,
                    cycles: CYC_W'(CIT_CYCLES_RST), cond: 1'b0, next_fetch: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    cit_cycle_counter #(
        .CYC_W (CYC_W)
    ) u_counter (
        .clk        (clk),
        .nrst       (nrst),
        .load       (cnt_load),
        .load_value (CYC_W'(total_cycles)),
        .remaining  (cnt_remaining),
        .last       (cnt_last)
    );

    assign op_ready     = st.ready;
    assign busy         = st.busy;
    assign instr_bytes  = st.bytes;
    assign instr_cycles = st.cycles;
    assign cond_branch  = st.cond;
    assign next_fetch   = st.next_fetch;

    // Checking helpers
    logic       accept;
    logic [3:0] busy_len;

    assign accept = op_valid && op_ready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_len <= 4'h0;
        end else if (busy) begin
            busy_len <= busy_len + 4'h1;
        end else begin
            busy_len <= 4'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_BUSY_LENGTH: assert property ($fell(busy) |-> busy_len == 4'(instr_cycles))
        else $error("busy length differs from reported cycles");
    AST_FETCH_RELEASE: assert property ($fell(busy) |-> next_fetch && op_ready)
        else $error("fetch not released when execution ends");
    AST_BRANCH_TAKEN: assert property (accept && dec_cond |=>
        instr_cycles == CYC_W'($past(dec_cycles) + ($past(branch_taken) ? 4'h1 : 4'h0)))
        else $error("conditional branch cycles wrong");
    AST_ADD_REG: assert property (accept && opcode[3] && opcode[7:4] inside {4'h2, 4'h3, 4'h9}
        |=> instr_bytes == 2'h1 && instr_cycles == CYC_W'(1))
        else $error("register arithmetic timing wrong");
    AST_ARITH_DIRECT: assert property (accept && opcode inside {8'h25, 8'h35, 8'h95}
        |=> instr_bytes == 2'h2 && instr_cycles == CYC_W'(2))
        else $error("direct arithmetic timing wrong");
    AST_INDIRECT_ALU: assert property (accept && opcode[3:1] == 3'h3
        && opcode[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
        |=> instr_bytes == 2'h1 && instr_cycles == CYC_W'(2))
        else $error("indirect ALU timing wrong");
    AST_IMMEDIATE: assert property (accept && opcode inside {8'h24, 8'h34, 8'h94}
        |=> instr_bytes == 2'h2 && instr_cycles == CYC_W'(2))
        else $error("immediate arithmetic timing wrong");
    AST_LOGIC_DIRECT: assert property (accept && opcode inside {8'h43, 8'h53, 8'h63, 8'h85,
        8'h75, 8'h90} |=> instr_bytes == 2'h3 ##0 instr_cycles == CYC_W'(3))
        else $error("three byte timing wrong");
    AST_CODE_EXT: assert property (accept && opcode inside {8'h83, 8'h93, 8'hE0, 8'hF0,
        8'hE2, 8'hE3, 8'hF2, 8'hF3} |=> instr_bytes == 2'h1 && instr_cycles == CYC_W'(3))
        else $error("code or external memory timing wrong");
    AST_ACC_ONLY: assert property (accept && opcode inside {8'hE4, 8'hF4, 8'h03, 8'h13,
        8'h23, 8'h33, 8'hC4} |=> instr_cycles == CYC_W'(1) [*1] ##1 !busy)
        else $error("accumulator-only op not one cycle");
    AST_XCH: assert property (accept && opcode inside {8'hC5, 8'hC6, 8'hC7, 8'hD6, 8'hD7,
        8'hF6, 8'hF7} |=> instr_cycles == CYC_W'(2))
        else $error("exchange or indirect write timing wrong");
    AST_MAX_CYCLES: assert property (busy |-> instr_cycles <= CYC_W'(MAX_CYCLES))
        else $error("instruction exceeds eight cycles");
    // Counter and busy flag cover the same execution window
    AST_COUNT_BUSY: assert property (busy == (cnt_remaining != CYC_W'(0)))
        else $error("busy flag and cycle counter disagree");

    COV_TAKEN: cover property (accept && dec_cond && branch_taken);
    COV_NOT_TAKEN: cover property (accept && dec_cond && !branch_taken);
    COV_DIVIDE: cover property (accept && opcode == 8'h84 ##9 next_fetch);
    COV_BACK_TO_BACK: cover property (next_fetch && op_valid);

endmodule

/* File: hw/cit_timing_pkg.sv */
// Shared constants and types for the instruction timing decoder.
// Assumes a single clock domain; no software-visible registers.
package cit_timing_pkg;

    // Field widths of the decode results
    localparam int CIT_BYTES_W = 2;
    localparam int CIT_CYC_W   = 4;

    // Timing figures, in system clock cycles
    localparam int         CIT_MAX_CYCLES_INT = 8;
    localparam logic [3:0] CIT_MAX_CYCLES     = 4'h8;
    localparam logic [3:0] CIT_TAKEN_EXTRA    = 4'h1;
    localparam logic [3:0] CIT_COUNT_ONE      = 4'h1;
    localparam logic [3:0] CIT_COUNT_ZERO     = 4'h0;

    // Reset values of the sequencer outputs
    localparam logic [1:0] CIT_BYTES_RST  = 2'h0;
    localparam logic [3:0] CIT_CYCLES_RST = 4'h0;

    typedef enum logic [0:0] {
        CIT_IDLE = 1'b0,
        CIT_EXEC = 1'b1
    } cit_state_type;

endpackage

/* File: tb/cit_fetch_model.sv */
// Fetch-side model that offers opcodes to the timing decoder.
// Assumes the bench queues opcodes through push() and holds one clock domain.
`timescale 1ns/1ns
module cit_fetch_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       op_ready,
    output logic            op_valid,
    output logic      [7:0] opcode,
    output logic            branch_taken
);
    logic [12:0] pend[$];
    int          wait_cnt;

    // Entry: stall cycles before the offer, branch outcome, opcode
    task automatic push(input logic [7:0] op, input logic tk, input logic [3:0] stall);
        pend.push_back({stall, tk, op});
    endtask

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_valid <= 1'b0;
            opcode <= 8'h00;
            branch_taken <= 1'b0;
            wait_cnt = 0;
        end else if (op_valid && op_ready) begin
            // Released lines show the inverse, never the stale value
            op_valid <= 1'b0;
            opcode <= ~opcode;
            branch_taken <= ~branch_taken;
        end else if (!op_valid) begin
            if (pend.size() > 0 && wait_cnt >= int'(pend[0][12:9])) begin
                op_valid <= 1'b1;
                opcode <= pend[0][7:0];
                branch_taken <= pend[0][8];
                void'(pend.pop_front());
                wait_cnt = 0;
            end else begin
                // Idle lines wander every cycle
                opcode <= opcode + 8'h5b;
                branch_taken <= ~branch_taken;
                wait_cnt++;
            end
        end
    end
endmodule

/* File: tb/cit_instruction_timing_test.sv */
// Self-checking bench for the instruction timing decoder.
// Assumes the fetch model drives the opcode side; one clock, async reset.
`timescale 1ns/1ns
module cit_instruction_timing_test;
    import cit_timing_pkg::*;

    logic       clk;
    logic       nrst;
    logic       op_valid;
    logic [7:0] opcode;
    logic       branch_taken;
    logic       op_ready;
    logic [1:0] instr_bytes;
    logic [3:0] instr_cycles;
    logic       cond_branch;
    logic       busy;
    logic       next_fetch;
    int         fail_count;
    int         n_checks;
    int         rem;
    logic [8:0] exp_q[$];
    // Opcode, span, conditional, bytes, not-taken cycles
    logic [23:0] op_table[$] = '{
        24'h28_8011, 24'h38_8011, 24'h98_8011,
        24'h25_1022, 24'h35_1022, 24'h95_1022,
        24'h26_2012, 24'h36_2012, 24'h96_2012,
        24'h56_2012, 24'h46_2012, 24'h66_2012,
        24'h24_1022, 24'h34_1022, 24'h94_1022,
        24'h53_1033, 24'h43_1033, 24'h63_1033,
        24'h52_1022, 24'h42_1022, 24'h62_1022,
        24'h58_8011, 24'h48_8011, 24'h68_8011,
        24'hE4_1011, 24'hF4_1011, 24'h23_1011, 24'h33_1011,
        24'h03_1011, 24'h13_1011, 24'hC4_1011,
        24'h85_1033, 24'h75_1033, 24'h90_1033,
        24'h93_1013, 24'h83_1013,
        24'hE0_1013, 24'hE2_2013, 24'hF0_1013, 24'hF2_2013,
        24'hC0_1022, 24'hD0_1022,
        24'hC8_8011, 24'hC5_1022, 24'hC6_2012, 24'hD6_2012,
        24'hF6_2012, 24'hA6_2022, 24'h76_2022,
        24'hA8_8022, 24'h78_8022,
        24'h84_1018, 24'hA4_1014,
        24'h40_1122, 24'h50_1122, 24'h60_1122, 24'h70_1122,
        24'h20_1133, 24'h30_1133, 24'h10_1133, 24'hB5_1134,
        24'hB4_1133, 24'hB8_8133, 24'hB6_2134, 24'hD8_8122, 24'hD5_1133
    };

    cit_instruction_timing u_cit_instruction_timing (
        .clk          (clk),
        .nrst         (nrst),
        .op_valid     (op_valid),
        .opcode       (opcode),
        .branch_taken (branch_taken),
        .op_ready     (op_ready),
        .instr_bytes  (instr_bytes),
        .instr_cycles (instr_cycles),
        .cond_branch  (cond_branch),
        .busy         (busy),
        .next_fetch   (next_fetch)
    );

    cit_fetch_model u_cit_fetch_model (
        .clk          (clk),
        .nrst         (nrst),
        .op_ready     (op_ready),
        .op_valid     (op_valid),
        .opcode       (opcode),
        .branch_taken (branch_taken)
    );

    always #5 clk = ~clk;

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Note the expected result, then hand the opcode to the fetch model
    task automatic issue(input logic [7:0] op, input logic tk, input logic [11:0] ent);
        logic [3:0] stall;
        stall = 4'($urandom_range(0, 3));
        exp_q.push_back({ent[8], ent[7:4], ent[3:0] + 4'(ent[8] & tk)});
        u_cit_fetch_model.push(op, tk, stall);
    endtask

    // Watches every take and the execution window behind it
    always begin : monitor
        logic       tk;
        logic [8:0] e;
        @(posedge clk);
        tk = nrst === 1'b1 && op_valid === 1'b1 && op_ready === 1'b1;
        #1;
        if (rem > 0) begin
            rem--;
            if (rem == 0) begin
                cmp_bit(next_fetch, 1'b1, "next_fetch after count");
                cmp_bit(busy, 1'b0, "busy after count");
            end else begin
                cmp_bit(busy, 1'b1, "busy during count");
                cmp_bit(op_ready, 1'b0, "op_ready during count");
            end
        end
        if (tk) begin
            e = exp_q.pop_front();
            cmp_val({2'b00, instr_bytes}, e[7:4], "instr_bytes");
            cmp_val(instr_cycles, e[3:0], "instr_cycles");
            cmp_bit(cond_branch, e[8], "cond_branch");
            cmp_bit(instr_cycles <= CIT_MAX_CYCLES, 1'b1, "limit");
            cmp_bit(busy, 1'b1, "busy first cycle");
            cmp_bit(next_fetch, 1'b0, "next_fetch one cycle");
            rem = int'(e[3:0]);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        logic [7:0]  op;
        logic [23:0] row;
        clk = 1'b0;
        nrst = 1'b0;
        fail_count = 0;
        n_checks = 0;
        rem = 0;
        void'($urandom(32'hd5fcf74a));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        cmp_bit(op_ready, 1'b1, "op_ready after reset");
        cmp_bit(busy, 1'b0, "busy after reset");
        cmp_val({2'b00, instr_bytes}, 4'h0, "bytes after reset");
        cmp_val(instr_cycles, 4'h0, "cycles after reset");
        cmp_bit(cond_branch, 1'b0, "cond after reset");
        cmp_bit(next_fetch, 1'b0, "next_fetch after reset");
        foreach (op_table[i]) begin
            row = op_table[i];
            // Branches go untaken then taken; others see a random outcome
            for (int k = 0; k < int'(row[15:12]); k++) begin
                op = row[23:16] + 8'(k);
                if (row[8]) begin
                    issue(op, 1'b0, row[11:0]);
                end
                issue(op, row[8] | 1'($urandom()), row[11:0]);
            end
        end
        repeat (20000) begin
            if (exp_q.size() == 0 && rem == 0) begin
                break;
            end
            @(posedge clk);
        end
        cmp_bit(exp_q.size() == 0 && rem == 0, 1'b1, "all results seen");
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
